// file: hdl/cbs_pkg.sv
package cbs_pkg;
  // ----------------------------------------------------------------
  // Configuration indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BASE_HIGH = 8'h13;
  localparam logic [7:0] IDX_FDC_SHADOW = 8'h14;
  localparam logic [7:0] IDX_UART1_SHADOW = 8'h15;
  localparam logic [7:0] IDX_UART2_SHADOW = 8'h16;
  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] BASE_HIGH_RST = 8'h00;
  localparam logic [7:0] BASE_HIGH_MASK = 8'h07;
  localparam logic [7:0] INDEX_RST = 8'h00;
  localparam logic [7:0] FDC_SHADOW_RST = 8'h80;
  localparam logic [7:0] FDC_KEEP_MASK = 8'hDF;
  localparam logic [7:0] FCR_SHADOW_RST = 8'h00;
  localparam logic [7:0] FCR_KEEP_MASK = 8'hC9;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FDC_RATE_LSB = 0;
  localparam int FDC_PRECOMP_LSB = 2;
  localparam int FDC_LOWPWR_BIT = 6;
  localparam int FDC_SRST_BIT = 7;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXFL_BIT = 1;
  localparam int FCR_TXFL_BIT = 2;
  localparam int FCR_TRIG_LSB = 6;
  localparam int BASE_HI_LSB = 8;
  localparam int BASE_HI_MSB = 10;
  // ----------------------------------------------------------------
  // Receive trigger levels in bytes
  // ----------------------------------------------------------------
  localparam logic [3:0] TRIG_LVL0 = 4'h1;
  localparam logic [3:0] TRIG_LVL1 = 4'h4;
  localparam logic [3:0] TRIG_LVL2 = 4'h8;
  localparam logic [3:0] TRIG_LVL3 = 4'hE;
endpackage

// file: hdl/cbs_fcr_shadow.sv
`timescale 1ns/1ps
module cbs_fcr_shadow
  import cbs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic rt_wr,
  input wire logic [7:0] rt_wdata,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] shadow,
  output logic fifo_en,
  output logic rx_flush,
  output logic tx_flush,
  output logic [3:0] rx_trigger
);
  logic [7:0] shadow_q;
  logic [7:0] shadow_d;
  logic rx_flush_q;
  logic tx_flush_q;
  logic [3:0] trig_q;
  logic [3:0] trig_d;
  wire wr_any = rt_wr | cfg_wr;
  // Runtime write wins a same-cycle collision with a config write
  wire [7:0] wdata = rt_wr ? rt_wdata : cfg_wdata;

  // ----------------------------------------------------------------
  // Shadow update
  // ----------------------------------------------------------------
  // Flush bits never stick, bits 4-5 stay zero, DMA bit only stored
  assign shadow_d = wr_any ? (wdata & FCR_KEEP_MASK) : shadow_q;
  always_comb begin
    case (shadow_d[FCR_TRIG_LSB +: 2])
      2'b00: trig_d = TRIG_LVL0;
      2'b01: trig_d = TRIG_LVL1;
      2'b10: trig_d = TRIG_LVL2;
      default: trig_d = TRIG_LVL3;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_q <= FCR_SHADOW_RST;
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
      trig_q <= TRIG_LVL0;
    end else begin
      shadow_q <= shadow_d;
      rx_flush_q <= wr_any & wdata[FCR_RXFL_BIT];
      tx_flush_q <= wr_any & wdata[FCR_TXFL_BIT];
      trig_q <= trig_d;
    end
  end

  assign shadow = shadow_q;
  assign fifo_en = shadow_q[FCR_EN_BIT];
  assign rx_flush = rx_flush_q;
  assign tx_flush = tx_flush_q;
  assign rx_trigger = trig_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rx_flush;
    @(posedge sys_clk) disable iff (!arst_n)
    (wr_any && wdata[FCR_RXFL_BIT]) |=> rx_flush ##1 !rx_flush || wr_any;
  endproperty
  a_rx_flush: assert property (p_rx_flush)
    else $error("receive flush pulse missing");
  property p_tx_flush;
    @(posedge sys_clk) disable iff (!arst_n)
    (wr_any && !wdata[FCR_TXFL_BIT]) |=> !tx_flush;
  endproperty
  a_tx_flush: assert property (p_tx_flush)
    else $error("transmit flush without request");
  property p_fcr_zero_bits;
    @(posedge sys_clk) disable iff (!arst_n)
    shadow[5:4] == 2'b00 && shadow[2:1] == 2'b00;
  endproperty
  a_fcr_zero_bits: assert property (p_fcr_zero_bits)
    else $error("fifo control zero bits set");
  property p_trigger;
    @(posedge sys_clk) disable iff (!arst_n)
    wr_any && wdata[7:6] == 2'b11 |=> rx_trigger == 4'hE;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger level not fourteen");
endmodule

// file: hdl/cbs_top.sv
`timescale 1ns/1ps
module cbs_top
  import cbs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic hard_rst,
  input wire logic cfg_state,
  input wire logic [7:0] config_port_base_low,
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output logic cfg_port_hit,
  output logic [7:0] config_port_base_high,
  input wire logic fdc_rate_wr,
  input wire logic [7:0] fdc_rate_wdata,
  output logic [1:0] fdc_data_rate,
  output logic [2:0] write_precomp_field,
  output logic manual_low_power_bit,
  output logic fdc_soft_reset,
  input wire logic uart1_fcr_wr,
  input wire logic [7:0] uart1_fcr_wdata,
  output logic uart1_fifo_en,
  output logic uart1_rx_flush,
  output logic uart1_tx_flush,
  output logic [3:0] uart1_rx_trigger,
  input wire logic uart2_fcr_wr,
  input wire logic [7:0] uart2_fcr_wdata,
  output logic uart2_fifo_en,
  output logic uart2_rx_flush,
  output logic uart2_tx_flush,
  output logic [3:0] uart2_rx_trigger
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The decoder qualifies exactly sixteen address bits
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("cbs_top supports only ADDR_W of 16");
  end

  logic [7:0] base_high_q;
  logic [7:0] base_high_d;
  logic [7:0] index_q;
  logic [7:0] index_d;
  logic [7:0] fdc_shadow_q;
  logic [7:0] fdc_shadow_d;
  logic fdc_srst_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic [7:0] uart1_shadow;
  logic [7:0] uart2_shadow;
  logic [7:0] data_mux;

  // ----------------------------------------------------------------
  // Configuration port decoder
  // ----------------------------------------------------------------
  // Bit 0 picks index or data port, so the base is always even
  wire upper_zero = io_addr[15:11] == 5'b00000;
  wire high_match =
    io_addr[BASE_HI_MSB:BASE_HI_LSB] == base_high_q[2:0];
  wire low_match = io_addr[7:1] == config_port_base_low[7:1];
  wire addr_hit = upper_zero & high_match & low_match;
  wire index_port = addr_hit & ~io_addr[0];
  wire data_port = addr_hit & io_addr[0];
  wire cfg_access = cfg_state & addr_hit;

  wire index_wr = cfg_state & io_wr & index_port;
  wire data_wr = cfg_state & io_wr & data_port;
  wire base_high_wr = data_wr & (index_q == IDX_BASE_HIGH);
  wire uart1_cfg_wr = data_wr & (index_q == IDX_UART1_SHADOW);
  wire uart2_cfg_wr = data_wr & (index_q == IDX_UART2_SHADOW);
  wire rd_take = cfg_access & io_rd;

  // ----------------------------------------------------------------
  // Base-high and index registers
  // ----------------------------------------------------------------
  // Hard reset outranks a write landing in the same cycle
  assign base_high_d = hard_rst ? BASE_HIGH_RST :
                       base_high_wr ? (io_wdata & BASE_HIGH_MASK) :
                       base_high_q;
  assign index_d = index_wr ? io_wdata : index_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      base_high_q <= BASE_HIGH_RST;
      index_q <= INDEX_RST;
    end else begin
      base_high_q <= base_high_d;
      index_q <= index_d;
    end
  end

  // ----------------------------------------------------------------
  // Floppy data-rate shadow
  // ----------------------------------------------------------------
  // The reset bit reads back as one: it only pulses the controller
  assign fdc_shadow_d = fdc_rate_wr ?
    ((fdc_rate_wdata & FDC_KEEP_MASK) | FDC_SHADOW_RST) :
    fdc_shadow_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fdc_shadow_q <= FDC_SHADOW_RST;
      fdc_srst_q <= 1'b0;
    end else begin
      fdc_shadow_q <= fdc_shadow_d;
      fdc_srst_q <= fdc_rate_wr & ~fdc_rate_wdata[FDC_SRST_BIT];
    end
  end

  assign fdc_data_rate = fdc_shadow_q[FDC_RATE_LSB +: 2];
  assign write_precomp_field = fdc_shadow_q[FDC_PRECOMP_LSB +: 3];
  assign manual_low_power_bit = fdc_shadow_q[FDC_LOWPWR_BIT];
  assign fdc_soft_reset = fdc_srst_q;

  // ----------------------------------------------------------------
  // UART FIFO-control shadows
  // ----------------------------------------------------------------
  cbs_fcr_shadow u_uart1_fcr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .rt_wr(uart1_fcr_wr),
    .rt_wdata(uart1_fcr_wdata),
    .cfg_wr(uart1_cfg_wr),
    .cfg_wdata(io_wdata),
    .shadow(uart1_shadow),
    .fifo_en(uart1_fifo_en),
    .rx_flush(uart1_rx_flush),
    .tx_flush(uart1_tx_flush),
    .rx_trigger(uart1_rx_trigger)
  );

  cbs_fcr_shadow u_uart2_fcr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .rt_wr(uart2_fcr_wr),
    .rt_wdata(uart2_fcr_wdata),
    .cfg_wr(uart2_cfg_wr),
    .cfg_wdata(io_wdata),
    .shadow(uart2_shadow),
    .fifo_en(uart2_fifo_en),
    .rx_flush(uart2_rx_flush),
    .tx_flush(uart2_tx_flush),
    .rx_trigger(uart2_rx_trigger)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Indexes owned elsewhere read zero here so an outer mux can OR them
  always_comb begin
    case (index_q)
      IDX_BASE_HIGH: data_mux = base_high_q;
      IDX_FDC_SHADOW: data_mux = fdc_shadow_q;
      IDX_UART1_SHADOW: data_mux = uart1_shadow;
      IDX_UART2_SHADOW: data_mux = uart2_shadow;
      default: data_mux = 8'h00;
    endcase
  end

  assign rdata_d = !rd_take ? 8'h00 :
                   index_port ? index_q : data_mux;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rd_take;
    end
  end

  assign io_rdata = rdata_q;
  assign io_rvalid = rvalid_q;
  assign cfg_port_hit = addr_hit;
  assign config_port_base_high = base_high_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_base_high_reserved;
    @(posedge sys_clk) disable iff (!arst_n)
    base_high_wr |=> config_port_base_high[7:3] == 5'h00;
  endproperty
  a_base_high_reserved: assert property (p_base_high_reserved)
    else $error("base high reserved bits not zero");

  property p_base_switch;
    @(posedge sys_clk) disable iff (!arst_n)
    (base_high_wr && !hard_rst) |=>
      config_port_base_high[2:0] == $past(io_wdata[2:0]);
  endproperty
  a_base_switch: assert property (p_base_switch)
    else $error("base high write not applied next cycle");

  property p_hard_reset;
    @(posedge sys_clk) disable iff (!arst_n)
    hard_rst |=> config_port_base_high == 8'h00;
  endproperty
  a_hard_reset: assert property (p_hard_reset)
    else $error("hard reset did not clear base high");

  property p_decode;
    @(posedge sys_clk) disable iff (!arst_n)
    cfg_port_hit |-> io_addr[15:11] == 5'h00 &&
      io_addr[10:8] == config_port_base_high[2:0];
  endproperty
  a_decode: assert property (p_decode)
    else $error("decoder matched a foreign address");

  property p_cfg_only_read;
    @(posedge sys_clk) disable iff (!arst_n)
    !cfg_state |=> !io_rvalid && io_rdata == 8'h00;
  endproperty
  a_cfg_only_read: assert property (p_cfg_only_read)
    else $error("read answered outside configuration state");

  property p_fdc_read;
    @(posedge sys_clk) disable iff (!arst_n)
    (rd_take && data_port && index_q == IDX_FDC_SHADOW && !fdc_rate_wr)
      |=> io_rdata == $past(fdc_shadow_q) && io_rdata[5] == 1'b0;
  endproperty
  a_fdc_read: assert property (p_fdc_read)
    else $error("floppy shadow read mismatch");

  property p_low_power;
    @(posedge sys_clk) disable iff (!arst_n)
    fdc_rate_wr |=> manual_low_power_bit == $past(fdc_rate_wdata[6]);
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power bit not captured");

  property p_soft_reset;
    @(posedge sys_clk) disable iff (!arst_n)
    (fdc_rate_wr && !fdc_rate_wdata[7]) |=>
      fdc_soft_reset && fdc_shadow_q[7] ##1 !fdc_soft_reset || fdc_rate_wr;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset pulse wrong");

  property p_fdc_capture;
    @(posedge sys_clk) disable iff (!arst_n)
    fdc_rate_wr |=> {write_precomp_field, fdc_data_rate} ==
      $past(fdc_rate_wdata[4:0]);
  endproperty
  a_fdc_capture: assert property (p_fdc_capture)
    else $error("floppy shadow not updated");

  property p_uart_enable;
    @(posedge sys_clk) disable iff (!arst_n)
    uart2_fcr_wr |=> uart2_fifo_en == $past(uart2_fcr_wdata[0]);
  endproperty
  a_uart_enable: assert property (p_uart_enable)
    else $error("uart fifo enable not captured");

  property p_uart1_enable;
    @(posedge sys_clk) disable iff (!arst_n)
    uart1_fcr_wr |=> uart1_fifo_en == $past(uart1_fcr_wdata[0]);
  endproperty
  a_uart1_enable: assert property (p_uart1_enable)
    else $error("first uart fifo enable not captured");

  property p_uart2_read;
    @(posedge sys_clk) disable iff (!arst_n)
    (rd_take && data_port && index_q == IDX_UART2_SHADOW && !io_wr)
      |=> io_rdata == $past(uart2_shadow);
  endproperty
  a_uart2_read: assert property (p_uart2_read)
    else $error("second uart shadow read mismatch");

  property p_read_answer;
    @(posedge sys_clk) disable iff (!arst_n)
    rd_take |=> io_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("configuration read not answered");

  property p_base_high_read;
    @(posedge sys_clk) disable iff (!arst_n)
    (rd_take && data_port && index_q == IDX_BASE_HIGH) |=>
      io_rdata[7:3] == 5'h00;
  endproperty
  a_base_high_read: assert property (p_base_high_read)
    else $error("base high reserved bits read nonzero");

  property p_precomp;
    @(posedge sys_clk) disable iff (!arst_n)
    fdc_rate_wr |=> write_precomp_field == $past(fdc_rate_wdata[4:2]);
  endproperty
  a_precomp: assert property (p_precomp)
    else $error("precompensation setting not captured");

  property p_upper_refused;
    @(posedge sys_clk) disable iff (!arst_n)
    io_addr[15:11] != 5'h00 |-> !cfg_port_hit;
  endproperty
  a_upper_refused: assert property (p_upper_refused)
    else $error("decoder hit with upper address bits set");
endmodule

// file: dv/cbs_host.sv
`timescale 1ns/1ps
module cbs_host
  import cbs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic io_rvalid,
  input wire logic [7:0] io_rdata,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  output logic [7:0] config_port_base_low
);
  // Index port address as the host believes it to be
  logic [15:0] base = 16'h002E;

  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
    config_port_base_low = 8'h2E;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Released lines show the inverse so a stale value never looks valid
  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge sys_clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask

  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d,
                        output logic ok);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    #1;
    ok = io_rvalid;
    d = io_rdata;
  endtask

  // ----------------------------------------------------------------
  // Indexed access
  // ----------------------------------------------------------------
  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] d);
    bus_wr(base, idx);
    bus_wr(base | 16'h0001, d);
  endtask

  task automatic cfg_read(input logic [7:0] idx, output logic [7:0] d,
                          output logic ok);
    bus_wr(base, idx);
    bus_rd(base | 16'h0001, d, ok);
  endtask

  // Low byte is staged after the high byte write and lands on the same edge
  // that takes it, so the decoder never sees a half-moved base
  task automatic move_base(input logic [15:0] nb);
    cfg_write(IDX_BASE_HIGH, nb[15:8]);
    config_port_base_low <= nb[7:0];
    base = {nb[15:8] & BASE_HIGH_MASK, nb[7:1], 1'b0};
  endtask

  // Park an address with no strobe so the decoder hit can be observed
  task automatic probe(input logic [15:0] a);
    @(posedge sys_clk);
    io_addr <= a;
    #1;
  endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cbs_pkg::*;
  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] sh;
    logic [3:0] trig;
  } cbs_row_t;

  logic sys_clk, arst_n, hard_rst, cfg_state;
  logic fdc_rate_wr, uart1_fcr_wr, uart2_fcr_wr;
  logic [7:0] fdc_rate_wdata, uart1_fcr_wdata, uart2_fcr_wdata;
  logic [15:0] io_addr;
  logic io_wr, io_rd, io_rvalid, cfg_port_hit;
  logic [7:0] io_wdata, io_rdata, config_port_base_low;
  logic [7:0] config_port_base_high;
  logic [1:0] fdc_data_rate;
  logic [2:0] write_precomp_field;
  logic manual_low_power_bit, fdc_soft_reset;
  logic uart1_fifo_en, uart1_rx_flush, uart1_tx_flush;
  logic uart2_fifo_en, uart2_rx_flush, uart2_tx_flush;
  logic [3:0] uart1_rx_trigger, uart2_rx_trigger;
  int error_cnt = 0;
  int check_count = 0;
  cbs_row_t rows [4] = '{'{8'h01, 8'h01, 4'h1}, '{8'h47, 8'h41, 4'h4},
                         '{8'h8A, 8'h88, 4'h8}, '{8'hFC, 8'hC8, 4'hE}};

  cbs_top #(.ADDR_W(16)) cbs_top_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .hard_rst(hard_rst), .cfg_state(cfg_state),
    .config_port_base_low(config_port_base_low), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .cfg_port_hit(cfg_port_hit),
    .config_port_base_high(config_port_base_high),
    .fdc_rate_wr(fdc_rate_wr), .fdc_rate_wdata(fdc_rate_wdata),
    .fdc_data_rate(fdc_data_rate),
    .write_precomp_field(write_precomp_field),
    .manual_low_power_bit(manual_low_power_bit),
    .fdc_soft_reset(fdc_soft_reset), .uart1_fcr_wr(uart1_fcr_wr),
    .uart1_fcr_wdata(uart1_fcr_wdata), .uart1_fifo_en(uart1_fifo_en),
    .uart1_rx_flush(uart1_rx_flush), .uart1_tx_flush(uart1_tx_flush),
    .uart1_rx_trigger(uart1_rx_trigger), .uart2_fcr_wr(uart2_fcr_wr),
    .uart2_fcr_wdata(uart2_fcr_wdata), .uart2_fifo_en(uart2_fifo_en),
    .uart2_rx_flush(uart2_rx_flush), .uart2_tx_flush(uart2_tx_flush),
    .uart2_rx_trigger(uart2_rx_trigger));

  cbs_host cbs_host_inst (.sys_clk(sys_clk), .io_rvalid(io_rvalid),
    .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata),
    .config_port_base_low(config_port_base_low));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Runtime write to floppy (0) or a UART (1, 2); returns in cycle c1
  task automatic pulse(input int w, input logic [7:0] d);
    @(posedge sys_clk);
    case (w)
      0: {fdc_rate_wr, fdc_rate_wdata} <= {1'b1, d};
      1: {uart1_fcr_wr, uart1_fcr_wdata} <= {1'b1, d};
      default: {uart2_fcr_wr, uart2_fcr_wdata} <= {1'b1, d};
    endcase
    @(posedge sys_clk);
    fdc_rate_wr <= 1'b0;
    uart1_fcr_wr <= 1'b0;
    uart2_fcr_wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    cbs_host_inst.cfg_read(idx, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, exp);
  endtask

  function automatic logic [7:0] fcr_out(input int u);
    if (u == 1) begin
      return {uart1_rx_trigger, uart1_tx_flush, uart1_rx_flush,
              uart1_fifo_en, 1'b0};
    end
    return {uart2_rx_trigger, uart2_tx_flush, uart2_rx_flush,
            uart2_fifo_en, 1'b0};
  endfunction

  function automatic logic [7:0] fdc_out();
    return {fdc_soft_reset, manual_low_power_bit, 1'b0,
            write_precomp_field, fdc_data_rate};
  endfunction

  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic ok;
    {arst_n, hard_rst, cfg_state} = 3'b001;
    {fdc_rate_wr, uart1_fcr_wr, uart2_fcr_wr} = 3'b000;
    {fdc_rate_wdata, uart1_fcr_wdata, uart2_fcr_wdata} = 24'h000000;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(config_port_base_high, 8'h00);
    check({uart1_rx_trigger, uart2_rx_trigger}, 8'h11);
    rd_chk(IDX_BASE_HIGH, 8'h00);
    $display("test reset done");
    for (int u = 1; u <= 2; u++) begin
      foreach (rows[i]) begin
        pulse(u, rows[i].wd);
        check(fcr_out(u), {rows[i].trig, rows[i].wd[2:0], 1'b0});
        @(posedge sys_clk);
        #1;
        check(fcr_out(u) & 8'h0C, 8'h00);
        rd_chk(8'h14 + u[7:0], rows[i].sh);
      end
      $display("test fifo control uart%0d done", u);
    end
    pulse(0, 8'h40);
    check(fdc_out(), 8'hC0);
    @(posedge sys_clk);
    #1;
    check({7'h00, fdc_soft_reset}, 8'h00);
    rd_chk(IDX_FDC_SHADOW, 8'hC0);
    pulse(0, 8'hBF);
    check(fdc_out(), 8'h1F);
    cbs_host_inst.cfg_write(IDX_FDC_SHADOW, 8'h00);
    rd_chk(IDX_FDC_SHADOW, 8'h9F);
    $display("test floppy shadow done");
    // Odd low byte and set upper bits probe the decoder masking
    cbs_host_inst.move_base(16'hFF4F);
    #1;
    check(config_port_base_high, 8'h07);
    rd_chk(IDX_BASE_HIGH, 8'h07);
    cbs_host_inst.bus_rd(16'h002F, d, ok);
    check({7'h00, ok}, 8'h00);
    cbs_host_inst.bus_rd(16'hF74F, d, ok);
    check({7'h00, ok}, 8'h00);
    @(posedge sys_clk);
    hard_rst <= 1'b1;
    @(posedge sys_clk);
    hard_rst <= 1'b0;
    #1;
    check(config_port_base_high, 8'h00);
    cbs_host_inst.base[15:8] = 8'h00;
    rd_chk(IDX_BASE_HIGH, 8'h00);
    $display("test base relocation done");
    @(posedge sys_clk);
    cfg_state <= 1'b0;
    cbs_host_inst.cfg_write(IDX_UART1_SHADOW, 8'h01);
    cbs_host_inst.bus_rd(16'h004F, d, ok);
    check({7'h00, ok}, 8'h00);
    cbs_host_inst.probe(16'h004F);
    check({7'h00, cfg_port_hit}, 8'h01);
    cbs_host_inst.probe(16'h084F);
    check({7'h00, cfg_port_hit}, 8'h00);
    @(posedge sys_clk);
    cfg_state <= 1'b1;
    rd_chk(IDX_UART1_SHADOW, 8'hC8);
    $display("test configuration state done");
    summarize();
  end
endmodule
